// file: hdl/e1es_consts.vh
// Purpose: constants of the receive elastic store with gapped channel clock
// Assumes: register index times four gives the APB byte address
// Notes:   store timing is counted in edges of the sampled line and system clocks, APB timing in clock cycles
//
// Operation
// - Rate select on: backplane frame is F-bit plus 24 channels.
// - Rate select on: channels with blank bit 1 dropped, 0 forwarded.
// - Blank bits reset so channels 25 to 32 are dropped.
// - Rate select on: F-bit position is always driven to one.
// - Blank bits in four byte registers, channel 1 at bit 0 of first.
// - Sync pin is a sync input or a frame/multiframe pulse output.
// - With reinsertion, sync input realigns multiframe; else frame boundary only.
// - Network frame sync marks line-side frames, store enabled or bypassed.
// - Multiframe sync marks backplane-side multiframes delayed through the store; bypassed, line-side.
// - Store reset leaves delay between N bytes and a frame plus N.
// - Store align leaves delay between half and one and a half frames; the code restarts the reader in the other frame below half, up to two frames.
// - Minimum delay mode limits store depth to 32 bits; the code only puts the reader in the writer frame at each wrap, up to a frame.
// - Minimum delay mode disables all slip detection and slips.
// - Gapped enable outputs channel clock only in selected channels.
// - 56k format omits the clock pulse of the last channel bit.
// - Gapped select bits in four byte registers, 1 enables clocks.
// - Gapped clock from line clock when bypassed, system clock otherwise.
// - Empty store repeats a frame, full store deletes one, flags set.
// - Rate conversion slips at 9 or 2 bytes separation per zone.
// - Reset edge puts reader in writer frame; slip zone forces opposite.
`ifndef E1ES_CONSTS_VH
`define E1ES_CONSTS_VH

// Register indexes
`define E1ES_IDX_IO_CONFIG     8'h84
`define E1ES_IDX_CONTROL       8'h85
`define E1ES_IDX_STATUS        8'h93
`define E1ES_IDX_BLANK1        8'hc0
`define E1ES_IDX_BLANK2        8'hc1
`define E1ES_IDX_BLANK3        8'hc2
`define E1ES_IDX_BLANK4        8'hc3
`define E1ES_IDX_GAP1          8'hcc
`define E1ES_IDX_GAP2          8'hcd
`define E1ES_IDX_GAP3          8'hce
`define E1ES_IDX_GAP4          8'hcf

// Control fields
`define E1ES_CTL_ENABLE        0
`define E1ES_CTL_MIN_DELAY     1
`define E1ES_CTL_RESET         2
`define E1ES_CTL_ALIGN         3
`define E1ES_CTL_SLIP_ZONE     4
`define E1ES_CTL_GAP_ENABLE    6
`define E1ES_CTL_FMT56         7

// I/O configuration fields
`define E1ES_IO_SYNC_OUT       0
`define E1ES_IO_MF_SELECT      1
`define E1ES_IO_T1_RATE        4
`define E1ES_IO_SIG_REINSERT   6

// Status fields
`define E1ES_ST_SLIP           5
`define E1ES_ST_UNDERFLOW      6
`define E1ES_ST_OVERFLOW       7

// Reset values
`define E1ES_RST_BLANK_LOW     8'h00
`define E1ES_RST_BLANK4        8'hff
`define E1ES_RST_ZERO          8'h00

// Frame geometry and slip thresholds, in bits and bytes
`define E1ES_T1_LAST_BIT       8'hc0
`define E1ES_E1_LAST_BIT       8'hff
`define E1ES_SLIP_ZONE0_BYTES  6'h09
`define E1ES_SLIP_ZONE1_BYTES  6'h02
`define E1ES_NATIVE_BYTES      6'h01
`define E1ES_HALF_FRAME_BYTES  7'h10
`define E1ES_FRAME_BYTES       7'h20
`define E1ES_MIN_DELAY_BYTES   7'h04
`define E1ES_NO_SLOT           6'h20

`endif

// file: hdl/e1es_frame_store.v
// Purpose: two-frame byte store, 32 timeslots per frame
// Assumes: one write and one asynchronous read per clock
// Notes:   address is {frame, timeslot}
`timescale 1ns/1ps
`default_nettype none
module e1es_frame_store (
  // Clock
  input  wire       clock,
  // Write side
  input  wire       wr_en,
  input  wire [5:0] wr_addr,
  input  wire [7:0] wr_data,
  // Read side
  input  wire [5:0] rd_addr,
  output wire [7:0] rd_data
);
  reg [7:0] mem [0:63];

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// file: hdl/e1es_rx_elastic_store.v
// Purpose: receive elastic store with E1 to 24-channel mapping and gapped clock
// Assumes: line and system clocks are synchronous level inputs, far slower than clock
// Notes:   registers over APB with one wait state
//
// Decided for this implementation: the APB slave port.
`include "e1es_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module e1es_rx_elastic_store (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Line side from the framer
  input  wire        rx_line_clock,
  input  wire        rx_line_data,
  input  wire        rx_line_frame_start,
  input  wire        rx_line_mf_start,
  // Backplane side
  input  wire        rx_system_clock,
  output reg         rx_serial_data_out,
  output reg         rx_network_frame_sync,
  output reg         rx_multiframe_sync,
  input  wire        rx_sync_pin_in,
  output reg         rx_sync_pin_out,
  output wire        rx_sync_pin_oe,
  output reg         rx_channel_clock
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [31:0] rx_blank_channel_select;
  reg  [31:0] rx_gapped_clock_select;
  reg  [7:0]  rx_estore_control;
  reg  [7:0]  rx_io_config;
  reg  [7:0]  rx_latched_status_four;
  reg         ack;

  wire        setup_wr;
  wire        acc;
  wire [7:0]  idx;
  wire        mapped;
  wire        bus_wr;

  function is_mapped;
    input [11:0] a;
    reg   [7:0]  i;
    begin
      i = a[9:2];
      is_mapped = (a[11:10] == 2'b00) && (a[1:0] == 2'b00) &&
                  ((i == `E1ES_IDX_IO_CONFIG) || (i == `E1ES_IDX_CONTROL) ||
                   (i == `E1ES_IDX_STATUS) ||
                   ((i >= `E1ES_IDX_BLANK1) && (i <= `E1ES_IDX_BLANK4)) ||
                   ((i >= `E1ES_IDX_GAP1) && (i <= `E1ES_IDX_GAP4)));
    end
  endfunction

  assign acc      = psel & penable;
  assign idx      = paddr[9:2];
  assign mapped   = is_mapped(paddr);
  assign pready   = ack;
  assign pslverr  = ack & ~mapped;
  assign bus_wr   = acc & ack & pwrite & mapped;
  assign setup_wr = 1'b0;

  // Single wait state so read data comes from a flip-flop
  always @(posedge clock) begin
    if (reset) begin
      ack    <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ack <= acc & ~ack;
      if (acc & ~ack & ~pwrite) begin
        prdata <= 32'h0000_0000;
        case (idx)
          `E1ES_IDX_IO_CONFIG: prdata[7:0] <= rx_io_config;
          `E1ES_IDX_CONTROL:   prdata[7:0] <= rx_estore_control;
          `E1ES_IDX_STATUS:    prdata[7:0] <= rx_latched_status_four;
          `E1ES_IDX_BLANK1:    prdata[7:0] <= rx_blank_channel_select[7:0];
          `E1ES_IDX_BLANK2:    prdata[7:0] <= rx_blank_channel_select[15:8];
          `E1ES_IDX_BLANK3:    prdata[7:0] <= rx_blank_channel_select[23:16];
          `E1ES_IDX_BLANK4:    prdata[7:0] <= rx_blank_channel_select[31:24];
          `E1ES_IDX_GAP1:      prdata[7:0] <= rx_gapped_clock_select[7:0];
          `E1ES_IDX_GAP2:      prdata[7:0] <= rx_gapped_clock_select[15:8];
          `E1ES_IDX_GAP3:      prdata[7:0] <= rx_gapped_clock_select[23:16];
          `E1ES_IDX_GAP4:      prdata[7:0] <= rx_gapped_clock_select[31:24];
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      always @(posedge clock) begin
        if (reset) begin
          rx_blank_channel_select[g*8+7:g*8] <= (g == 3) ? `E1ES_RST_BLANK4
                                                         : `E1ES_RST_BLANK_LOW;
          rx_gapped_clock_select[g*8+7:g*8]  <= `E1ES_RST_ZERO;
        end else if (bus_wr) begin
          if (idx == `E1ES_IDX_BLANK1 + g) begin
            rx_blank_channel_select[g*8+7:g*8] <= pwdata[7:0];
          end
          if (idx == `E1ES_IDX_GAP1 + g) begin
            rx_gapped_clock_select[g*8+7:g*8] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (reset) begin
      rx_estore_control <= `E1ES_RST_ZERO;
      rx_io_config      <= `E1ES_RST_ZERO;
    end else if (bus_wr) begin
      if (idx == `E1ES_IDX_CONTROL) begin
        rx_estore_control <= pwdata[7:0] & 8'hdf;
      end
      if (idx == `E1ES_IDX_IO_CONFIG) begin
        rx_io_config <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modes and clock edges
  wire es_on    = rx_estore_control[`E1ES_CTL_ENABLE];
  wire min_dly  = rx_estore_control[`E1ES_CTL_MIN_DELAY];
  wire t1_rate  = rx_io_config[`E1ES_IO_T1_RATE];
  wire sync_out = rx_io_config[`E1ES_IO_SYNC_OUT];
  reg         line_q;
  reg         sys_q;
  wire        line_rise = rx_line_clock & ~line_q;
  wire        sys_rise  = rx_system_clock & ~sys_q;
  wire [5:0]  thr;

  // Slip zone applies to rate conversion only
  assign thr = ~t1_rate ? `E1ES_NATIVE_BYTES :
               rx_estore_control[`E1ES_CTL_SLIP_ZONE] ? `E1ES_SLIP_ZONE1_BYTES
                                                      : `E1ES_SLIP_ZONE0_BYTES;
  assign rx_sync_pin_oe = sync_out;

  ////////////////////////////////////////////////////////////////////////////
  // Line-side write
  reg  [7:0]  wbit;
  reg         wframe;
  reg  [6:0]  wsh;
  reg  [1:0]  mf_tag;
  reg  [5:0]  rpos;
  reg         rframe;
  wire [7:0]  widx   = rx_line_frame_start ? 8'h00 : wbit + 8'h01;
  wire        wr_en  = line_rise & (widx[2:0] == 3'h7);
  wire        ovf    = es_on & ~min_dly & (~wframe == rframe) & (rpos < thr);
  reg         ovf_ev;

  always @(posedge clock) begin
    if (reset) begin
      // Edge detector follows the pin through reset, no false edge on release
      line_q <= rx_line_clock;
      wbit   <= 8'h00;
      wframe <= 1'b0;
      wsh    <= 7'h00;
      mf_tag <= 2'b00;
      ovf_ev <= 1'b0;
      rx_network_frame_sync <= 1'b0;
    end else begin
      line_q <= rx_line_clock;
      ovf_ev <= 1'b0;
      if (line_rise) begin
        wbit <= widx;
        wsh  <= {wsh[5:0], rx_line_data};
        rx_network_frame_sync <= rx_line_frame_start;
        if (widx == 8'h00) begin
          if (ovf) begin
            ovf_ev <= 1'b1;
            mf_tag[wframe] <= rx_line_mf_start;
          end else begin
            wframe <= ~wframe;
            mf_tag[~wframe] <= rx_line_mf_start;
          end
        end
      end
    end
  end

  wire [7:0] rd_byte;
  wire [5:0] rd_addr;

  e1es_frame_store u_store (
    .clock   (clock),
    .wr_en   (wr_en),
    .wr_addr ({wframe, widx[7:3]}),
    .wr_data ({wsh, rx_line_data}),
    .rd_addr (rd_addr),
    .rd_data (rd_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Backplane-side read
  function [5:0] next_open;
    input [5:0]  from;
    input [31:0] blank;
    integer      i;
    reg          found;
    begin
      next_open = `E1ES_NO_SLOT;
      found = 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        if (!found && (i >= from) && !blank[i]) begin
          next_open = i[5:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  reg  [7:0] rbit;
  reg  [5:0] cursor;
  reg  [7:0] rsh;
  reg  [3:0] mf_cnt;
  reg  [4:0] cur_ch;
  reg  [2:0] cur_bit;
  reg        cur_valid;
  reg        ctl_rst_q;
  reg        ctl_aln_q;
  reg        pend_rst;
  reg        pend_aln;

  reg  [7:0] next_rbit;
  reg        next_rframe;
  reg  [5:0] next_cursor;
  reg  [5:0] next_slot;
  reg  [7:0] next_pos;
  reg        next_fbit;
  reg        next_under;
  reg  [6:0] next_sep;
  reg        wrap;

  always @* begin
    wrap = (rbit == (t1_rate ? `E1ES_T1_LAST_BIT : `E1ES_E1_LAST_BIT)) |
           (~sync_out & rx_sync_pin_in);
    next_rbit   = wrap ? 8'h00 : rbit + 8'h01;
    next_rframe = rframe;
    next_under  = 1'b0;
    next_sep    = (rframe == wframe) ? {2'b00, wbit[7:3]} - {1'b0, rpos}
                                     : `E1ES_FRAME_BYTES + {2'b00, wbit[7:3]} - {1'b0, rpos};
    if (wrap) begin
      if (min_dly) begin
        // Read trails write within one frame, no slips
        next_rframe = wframe;
      end else if ((~rframe == wframe) && ({1'b0, wbit[7:3]} <= thr)) begin
        next_under = 1'b1;
      end else begin
        next_rframe = ~rframe;
      end
    end
    if (pend_rst) begin
      // Reader joins writer frame, or opposite in slip zone
      next_rbit   = 8'h00;
      next_rframe = ({1'b0, wbit[7:3]} <= thr) ? ~wframe : wframe;
    end else if (pend_aln && (next_sep < `E1ES_HALF_FRAME_BYTES)) begin
      next_rbit   = 8'h00;
      next_rframe = ~wframe;
    end
    next_fbit = t1_rate & (next_rbit == 8'h00);
    next_pos  = t1_rate ? next_rbit - 8'h01 : next_rbit;
    next_cursor = (next_rbit == 8'h00) ? 6'h00 : cursor;
    next_slot   = {1'b0, next_pos[7:3]};
    if (t1_rate) begin
      // Skip blanked E1 channels, slot held for the rest of the byte
      next_slot = (next_pos[2:0] == 3'h0) ? next_open(next_cursor, rx_blank_channel_select)
                                          : next_cursor - 6'h01;
    end
    if (~next_fbit && (next_pos[2:0] == 3'h0)) begin
      next_cursor = next_slot + 6'h01;
    end
  end

  assign rd_addr = {next_rframe, next_slot[4:0]};

  always @(posedge clock) begin
    if (reset) begin
      sys_q     <= rx_system_clock;
      rbit      <= 8'h00;
      rframe    <= 1'b1;
      cursor    <= 6'h00;
      rsh       <= 8'h00;
      rpos      <= 6'h00;
      mf_cnt    <= 4'h0;
      cur_ch    <= 5'h00;
      cur_bit   <= 3'h0;
      cur_valid <= 1'b0;
      ctl_rst_q <= 1'b0;
      ctl_aln_q <= 1'b0;
      pend_rst  <= 1'b0;
      pend_aln  <= 1'b0;
    end else begin
      sys_q     <= rx_system_clock;
      ctl_rst_q <= rx_estore_control[`E1ES_CTL_RESET];
      ctl_aln_q <= rx_estore_control[`E1ES_CTL_ALIGN];
      // Commands wait for the next backplane bit
      if (rx_estore_control[`E1ES_CTL_RESET] & ~ctl_rst_q) begin
        pend_rst <= 1'b1;
      end else if (sys_rise & es_on) begin
        pend_rst <= 1'b0;
      end
      if (rx_estore_control[`E1ES_CTL_ALIGN] & ~ctl_aln_q) begin
        pend_aln <= 1'b1;
      end else if (sys_rise & es_on) begin
        pend_aln <= 1'b0;
      end
      if (sys_rise & es_on) begin
        rbit      <= next_rbit;
        rframe    <= next_rframe;
        cursor    <= next_cursor;
        cur_ch    <= next_slot[4:0];
        cur_bit   <= next_pos[2:0];
        cur_valid <= ~next_fbit & ~next_slot[5];
        if (next_fbit || next_slot[5]) begin
          rsh <= 8'hff;
        end else if (next_pos[2:0] == 3'h0) begin
          rsh <= {rd_byte[6:0], 1'b1};
        end else begin
          rsh <= {rsh[6:0], 1'b1};
        end
        if (next_rbit == 8'h00) begin
          rpos <= 6'h00;
        end else if (~next_fbit && (next_pos[2:0] == 3'h7)) begin
          rpos <= rpos + 6'h01;
        end
        // Multiframe follows line tags or sync realignment
        if (next_rbit == 8'h00) begin
          if (~sync_out & rx_sync_pin_in & rx_io_config[`E1ES_IO_SIG_REINSERT]) begin
            mf_cnt <= 4'h0;
          end else if (mf_tag[next_rframe]) begin
            mf_cnt <= 4'h0;
          end else begin
            mf_cnt <= mf_cnt + 4'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial data, syncs and status
  wire next_mf0 = mf_tag[next_rframe] |
                  (~sync_out & rx_sync_pin_in & rx_io_config[`E1ES_IO_SIG_REINSERT]);

  always @(posedge clock) begin
    if (reset) begin
      rx_serial_data_out     <= 1'b1;
      rx_multiframe_sync     <= 1'b0;
      rx_sync_pin_out        <= 1'b0;
      rx_latched_status_four <= `E1ES_RST_ZERO;
    end else begin
      if (es_on & sys_rise) begin
        if (next_fbit || next_slot[5]) begin
          rx_serial_data_out <= 1'b1;
        end else if (next_pos[2:0] == 3'h0) begin
          rx_serial_data_out <= rd_byte[7];
        end else begin
          rx_serial_data_out <= rsh[7];
        end
        rx_multiframe_sync <= (next_rbit == 8'h00) & next_mf0;
        // Frame or multiframe pulse on the sync pin
        rx_sync_pin_out <= (next_rbit == 8'h00) &
                           (~rx_io_config[`E1ES_IO_MF_SELECT] | next_mf0);
      end else if (~es_on & line_rise) begin
        rx_serial_data_out <= rx_line_data;
        rx_multiframe_sync <= rx_line_mf_start;
        rx_sync_pin_out    <= rx_io_config[`E1ES_IO_MF_SELECT] ? rx_line_mf_start
                                                               : rx_line_frame_start;
      end
      // Sticky flags, set wins over write-one clear
      rx_latched_status_four <=
        ((bus_wr && (idx == `E1ES_IDX_STATUS)) ?
          (rx_latched_status_four & ~pwdata[7:0]) : rx_latched_status_four) |
        ({7'h00, ovf_ev} << `E1ES_ST_OVERFLOW) |
        ({7'h00, sys_rise & es_on & next_under} << `E1ES_ST_UNDERFLOW) |
        ({7'h00, ovf_ev | (sys_rise & es_on & next_under)} << `E1ES_ST_SLIP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel clock
  // Bit launched at this edge, so the gate meets its own bit and not the last
  wire [7:0] ln_bit   = line_rise ? widx : wbit;
  wire [4:0] gc_ch    = es_on ? (sys_rise ? next_slot[4:0] : cur_ch) : ln_bit[7:3];
  wire [2:0] gc_bit   = es_on ? (sys_rise ? next_pos[2:0] : cur_bit) : ln_bit[2:0];
  wire       gc_valid = es_on ? (sys_rise ? ~next_fbit & ~next_slot[5] : cur_valid) : 1'b1;
  wire       gc_src   = es_on ? rx_system_clock : rx_line_clock;

  always @(posedge clock) begin
    if (reset) begin
      rx_channel_clock <= 1'b0;
    end else if (rx_estore_control[`E1ES_CTL_GAP_ENABLE]) begin
      // Gate to selected channels, drop last bit at 56k
      rx_channel_clock <= gc_src & gc_valid & rx_gapped_clock_select[gc_ch] &
                          ~(rx_estore_control[`E1ES_CTL_FMT56] & (gc_bit == 3'h7));
    end else begin
      rx_channel_clock <= gc_valid & (gc_bit == 3'h0);
    end
  end

endmodule
`default_nettype wire

// file: verification/e1es_rx_monitor.sv
// Purpose: port checker for the receive elastic store
// Assumes: line and system clocks are slow levels sampled by clock
// Notes:   bound to every instance of the store
`timescale 1ns/1ps
`default_nettype none
module e1es_rx_monitor (
  // Clock, reset and APB
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line and backplane
  input wire logic        rx_line_clock,
  input wire logic        rx_line_frame_start,
  input wire logic        rx_system_clock,
  input wire logic        rx_serial_data_out,
  input wire logic        rx_network_frame_sync,
  input wire logic        rx_multiframe_sync,
  input wire logic        rx_sync_pin_out,
  input wire logic        rx_sync_pin_oe,
  input wire logic        rx_channel_clock
);
  logic sys_q;
  logic line_q;
  logic rise_d;
  logic edge_d;
  // Clock edges seen one cycle late, like the registered outputs
  always @(posedge clock) begin
    sys_q  <= rx_system_clock;
    line_q <= rx_line_clock;
    rise_d <= (rx_system_clock & ~sys_q) | (rx_line_clock & ~line_q);
    edge_d <= (rx_system_clock ^ sys_q) | (rx_line_clock ^ line_q);
  end
  default clocking dcb @(posedge clock); endclocking
  default disable iff (reset);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  AST_NET_SET: assert property (
    $rose(rx_line_clock) && rx_line_frame_start |=> rx_network_frame_sync)
    else $error("frame sync missing at line frame start");
  AST_NET_CLR: assert property (
    $rose(rx_line_clock) && !rx_line_frame_start |=> !rx_network_frame_sync)
    else $error("frame sync outside line frame start");
  AST_SER_STEP: assert property (
    $changed(rx_serial_data_out) && !$past(reset, 2) |-> rise_d)
    else $error("serial data moved without a clock rise");
  AST_MF_STEP: assert property (
    $changed(rx_multiframe_sync) && !$past(reset, 2) |-> rise_d)
    else $error("multiframe sync moved without a clock rise");
  AST_SYNC_STEP: assert property (
    $changed(rx_sync_pin_out) && !$past(reset, 2) |-> rise_d)
    else $error("sync output moved without a clock rise");
  // A register write may also move the channel clock two cycles later
  AST_CHCLK_STEP: assert property (
    $changed(rx_channel_clock) && !$past(reset, 2) &&
    !$past(psel && penable && pready && pwrite, 2) |-> edge_d)
    else $error("channel clock moved without a source edge");
  AST_OE_CFG: assert property (
    $changed(rx_sync_pin_oe) |-> $past(psel && penable && pready && pwrite))
    else $error("sync pin direction moved without a write");
endmodule
bind e1es_rx_elastic_store e1es_rx_monitor e1es_rx_monitor_i (.clock, .reset, .psel, .penable,
  .pwrite, .pready, .pslverr, .rx_line_clock, .rx_line_frame_start, .rx_system_clock,
  .rx_serial_data_out, .rx_network_frame_sync, .rx_multiframe_sync, .rx_sync_pin_out,
  .rx_sync_pin_oe, .rx_channel_clock);
`default_nettype wire

// file: verification/e1es_backplane_model.sv
// Purpose: backplane partner with a clock locked to the line
// Assumes: 193 backplane bits per 1024 clocks, one line frame
// Notes:   tallies ones and channel clock pulses per backplane frame
`timescale 1ns/1ps
`default_nettype none
module e1es_backplane_model (
  // Clock
  input wire logic        clock,
  // Backplane pins
  output var logic        rx_system_clock = 1'h0,
  output var logic        sync_drive = 1'h0,
  input wire logic        rx_serial_data_out,
  input wire logic        rx_channel_clock,
  // Per-frame tallies
  output logic [7:0]      ones_last,
  output logic [7:0]      pulses_last
);
  logic [10:0] acc = 11'h000;
  logic [7:0]  bit_no = 8'h00;
  logic [7:0]  ones = 8'h00;
  logic [7:0]  pulses = 8'h00;
  logic        chq = 1'h0;
  always @(posedge clock) begin
    chq <= rx_channel_clock;
    if (rx_channel_clock && !chq)
      pulses <= pulses + 8'h01;
    if (acc + 11'h182 >= 11'h400) begin
      acc <= acc + 11'h182 - 11'h400;
      rx_system_clock <= ~rx_system_clock;
      if (!rx_system_clock) begin
        sync_drive <= (bit_no == 8'hc0);
        ones <= ones + {7'h00, rx_serial_data_out};
        bit_no <= bit_no + 8'h01;
        if (bit_no == 8'hc0) begin
          bit_no <= 8'h00;
          ones_last <= ones + {7'h00, rx_serial_data_out};
          ones <= 8'h00;
          pulses_last <= pulses;
          pulses <= 8'h00;
        end
      end
    end else
      acc <= acc + 11'h182;
  end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: self-checking bench of the receive elastic store
// Assumes: line bit every 4 clocks, backplane clock from the partner
// Notes:   one line timeslot carries ones, all others zeros
`include "e1es_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] idx; logic [7:0] rst; logic [7:0] wr;} e1es_row_t;
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        rx_line_clock = 1'h0;
  logic        rx_line_data = 1'h0;
  logic        rx_line_frame_start = 1'h0;
  logic        rx_line_mf_start = 1'h0;
  logic [9:0]  lph = 10'h000;
  logic [3:0]  fno = 4'h0;
  logic [31:0] rd;
  logic        er;
  wire         pready, pslverr, rx_system_clock, sync_drive, rx_sync_pin_in;
  wire         rx_serial_data_out, rx_network_frame_sync, rx_multiframe_sync;
  wire         rx_sync_pin_out, rx_sync_pin_oe, rx_channel_clock;
  wire [31:0]  prdata;
  wire [7:0]   ones_last, pulses_last;
  int          err_total = 0;
  int          checks = 0;
  e1es_row_t   rows [8] = '{'{`E1ES_IDX_BLANK1, 8'h00, 8'h5a}, '{`E1ES_IDX_BLANK2, 8'h00, 8'ha5},
    '{`E1ES_IDX_BLANK3, 8'h00, 8'h3c}, '{`E1ES_IDX_BLANK4, 8'hff, 8'h81},
    '{`E1ES_IDX_GAP1, 8'h00, 8'h01}, '{`E1ES_IDX_GAP2, 8'h00, 8'h80},
    '{`E1ES_IDX_GAP3, 8'h00, 8'hf0}, '{`E1ES_IDX_GAP4, 8'h00, 8'h0f}};
  assign rx_sync_pin_in = rx_sync_pin_oe ? rx_sync_pin_out : sync_drive;
  e1es_rx_elastic_store e1es_rx_elastic_store_i (.clock, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .rx_line_clock, .rx_line_data,
    .rx_line_frame_start, .rx_line_mf_start, .rx_system_clock, .rx_serial_data_out,
    .rx_network_frame_sync, .rx_multiframe_sync, .rx_sync_pin_in, .rx_sync_pin_out,
    .rx_sync_pin_oe, .rx_channel_clock);
  e1es_backplane_model e1es_backplane_model_i (.clock, .rx_system_clock, .sync_drive,
    .rx_serial_data_out, .rx_channel_clock, .ones_last, .pulses_last);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clock = ~clock;
  end
  // Line frame of 256 bits, ones only in timeslot 24
  always @(posedge clock) begin
    lph <= lph + 10'h001;
    if (lph == 10'h3ff)
      fno <= fno + 4'h1;
    rx_line_clock <= lph[1];
    rx_line_data <= (lph[9:5] == 5'h18);
    rx_line_frame_start <= (lph[9:2] == 8'h00);
    rx_line_mf_start <= (lph[9:2] == 8'h00) && (fno == 4'h0);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic settle(input int frames, input string name);
    repeat (frames * 1024) @(posedge clock);
    $display("test %s done", name);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'h0;
    foreach (rows[i]) begin
      apb(1'h0, rows[i].idx, 8'h00);
      check(rd, {24'h0, rows[i].rst});
      apb(1'h1, rows[i].idx, rows[i].wr);
      apb(1'h0, rows[i].idx, 8'h00);
      check(rd, {24'h0, rows[i].wr});
      apb(1'h1, rows[i].idx, rows[i].rst);
    end
    $display("test registers done");
    apb(1'h1, 8'h01, 8'hff);
    apb(1'h0, 8'h01, 8'h00);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'h1, `E1ES_IDX_IO_CONFIG, 8'h11);
    @(posedge clock);
    check({31'h0, rx_sync_pin_oe}, 32'h1);
    apb(1'h1, `E1ES_IDX_IO_CONFIG, 8'h10);
    @(posedge clock);
    check({31'h0, rx_sync_pin_oe}, 32'h0);
    // Store reset toggled once clocks run, zone 0 for clustered blanks
    apb(1'h1, `E1ES_IDX_CONTROL, 8'h05);
    apb(1'h1, `E1ES_IDX_CONTROL, 8'h01);
    settle(4, "default blanking");
    check({24'h0, ones_last}, 32'h1);
    apb(1'h1, `E1ES_IDX_BLANK3, 8'h80);
    apb(1'h1, `E1ES_IDX_BLANK4, 8'hfe);
    settle(3, "moved blanking");
    check({24'h0, ones_last}, 32'h9);
    apb(1'h1, `E1ES_IDX_GAP1, 8'h01);
    apb(1'h1, `E1ES_IDX_CONTROL, 8'h41);
    settle(2, "gapped 64k");
    check({24'h0, pulses_last}, 32'h8);
    apb(1'h1, `E1ES_IDX_CONTROL, 8'hc1);
    settle(2, "gapped 56k");
    check({24'h0, pulses_last}, 32'h7);
    apb(1'h1, `E1ES_IDX_CONTROL, 8'h40);
    settle(2, "gapped bypass");
    check({24'h0, pulses_last}, 32'h8);
    reset <= 1'h1;
    repeat (2) @(posedge clock);
    reset <= 1'h0;
    apb(1'h0, `E1ES_IDX_BLANK4, 8'h00);
    check(rd, 32'hff);
    $display("test mid-run reset done");
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
